// ===== design/bldc_commutation_control.sv
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - Run while enabled, coast when disabled
// - Sense trip stops conduction for oscillator cycle
// - Fault on invalid code, disable, overcurrent
// - Fault also on undervoltage or overtemperature
// - Select input picks 60 or 120 phasing
// - Brake high blocks running and brakes
// - Direction input reverses rotation
// - Commutation comes only from sensor inputs
// - Optional delayed latched shutdown on persistent limit
// - Six sensor codes valid, two invalid
// - Reverse swaps upper and lower per phase
// - Brake: uppers off first, then lowers on
// - Invalid code: all drives off, fault asserted
module bldc_commutation_control #(
   parameter int SHUTDOWN_DELAY_CYCLES = bldc_pkg::SHUTDOWN_DELAY_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Rotor position sensors
   input wire logic position_sensor_a_i,
   input wire logic position_sensor_b_i,
   input wire logic position_sensor_c_i,
   // Motor control inputs
   input wire logic direction_i,
   input wire logic run_enable_i,
   input wire logic brake_i,
   input wire logic phase_60_select_i,
   // Protection inputs from the analog side
   input wire logic current_sense_i,
   input wire logic undervoltage_i,
   input wire logic thermal_shutdown_i,
   // Upper drives, low turns the switch on
   output logic upper_drive_a_n_o,
   output logic upper_drive_b_n_o,
   output logic upper_drive_c_n_o,
   // Lower drives, high turns the switch on
   output logic lower_drive_a_o,
   output logic lower_drive_b_o,
   output logic lower_drive_c_o,
   // Open-drain fault pin
   output logic fault_out_o,
   output logic fault_oe_n_o,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Interrupt
   output logic irq_o
);

   localparam int DELAY_W = $clog2(SHUTDOWN_DELAY_CYCLES + 1);
   localparam logic [DELAY_W-1:0] DELAY_LAST =
      DELAY_W'(SHUTDOWN_DELAY_CYCLES - 1);
   localparam logic [bldc_pkg::OSC_CNT_W-1:0] OSC_LAST =
      bldc_pkg::OSC_CNT_W'(bldc_pkg::OSC_CYCLES - 1);

   // Sensor code to commutation step, one table per phasing
   function automatic logic [2:0] step_of(input logic [2:0] code,
                                          input logic sel60);
      logic [2:0] step;
      step = bldc_pkg::STEP_INVALID;
      case (code)
         3'h4: step = 3'h0;
         3'h6: step = 3'h1;
         3'h7: step = sel60 ? 3'h2 : bldc_pkg::STEP_INVALID;
         3'h2: step = sel60 ? bldc_pkg::STEP_INVALID : 3'h2;
         3'h3: step = 3'h3;
         3'h1: step = 3'h4;
         3'h0: step = sel60 ? 3'h5 : bldc_pkg::STEP_INVALID;
         3'h5: step = sel60 ? bldc_pkg::STEP_INVALID : 3'h5;
         default: step = bldc_pkg::STEP_INVALID;
      endcase
      return step;
   endfunction : step_of

   // Step to forward phases: {lower one-hot, upper one-hot}, bit 0 is A
   function automatic logic [5:0] phases_of(input logic [2:0] step);
      logic [5:0] ph;
      ph = 6'h00;
      case (step)
         3'h0: ph = {3'h4, 3'h1};
         3'h1: ph = {3'h4, 3'h2};
         3'h2: ph = {3'h1, 3'h2};
         3'h3: ph = {3'h1, 3'h4};
         3'h4: ph = {3'h2, 3'h4};
         3'h5: ph = {3'h2, 3'h1};
         default: ph = 6'h00;
      endcase
      return ph;
   endfunction : phases_of

   logic [6:0] raw_bits;
   logic [6:0] sync_bits;
   logic [2:0] sensor_code;
   logic direction_s;
   logic enable_s;
   logic brake_s;
   logic sel60_s;
   logic [2:0] step;
   logic code_valid;
   logic [5:0] fwd_phases;
   logic [2:0] run_upper;
   logic [2:0] run_lower;
   logic run_ok;
   logic limit_active;
   logic [2:0] upper_next;
   logic [2:0] lower_next;
   logic fault_next;
   logic [2:0] upper_on_reg;
   logic [2:0] lower_on_reg;
   logic fault_reg;
   logic [bldc_pkg::OSC_CNT_W-1:0] osc_cnt_reg;
   logic osc_start;
   logic limit_reg;
   logic limit_next;
   logic seen_reg;
   logic [DELAY_W-1:0] delay_cnt_reg;
   logic [DELAY_W-1:0] delay_cnt_next;
   logic shutdown_reg;
   logic shutdown_set;
   logic shutdown_clear;
   logic latch_mode_reg;
   logic invalid_reg;
   logic bus_req;
   logic ack_reg;
   logic wr_take;
   logic [5:0] word_adr;
   logic hit_ctrl;
   logic hit_status;
   logic hit_irq_status;
   logic hit_irq_mask;
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic [31:0] rd_data_reg;
   logic [bldc_pkg::IRQ_W-1:0] events;
   logic [bldc_pkg::IRQ_W-1:0] w1c;
   logic [bldc_pkg::IRQ_W-1:0] irq_status_reg;
   logic [bldc_pkg::IRQ_W-1:0] irq_mask_reg;

   // Sensor and motor control inputs pass a two-flop synchroniser; the protection inputs are used unsynchronised
   assign raw_bits = {phase_60_select_i, brake_i, run_enable_i,
                      direction_i, position_sensor_c_i,
                      position_sensor_b_i, position_sensor_a_i};

   input_sync #(
      .WIDTH(7)
   ) u_input_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(raw_bits),
      .sync_o(sync_bits)
   );

   // Sensor code ordered A, B, C from the most significant bit
   assign sensor_code = {sync_bits[0], sync_bits[1], sync_bits[2]};
   assign direction_s = sync_bits[3];
   assign enable_s = sync_bits[4];
   assign brake_s = sync_bits[5];
   assign sel60_s = sync_bits[6];

   // Position decode depends on the sensors and phasing alone
   assign step = step_of(sensor_code, sel60_s);
   assign code_valid = step != bldc_pkg::STEP_INVALID;
   assign fwd_phases = phases_of(step);
   // Reverse exchanges upper and lower of the same phase
   assign run_upper = direction_s ? fwd_phases[2:0] : fwd_phases[5:3];
   assign run_lower = direction_s ? fwd_phases[5:3] : fwd_phases[2:0];

   // Any blocking condition forces a coast: uppers off, lowers low
   assign limit_active = limit_reg | current_sense_i;
   assign run_ok = code_valid && enable_s && !limit_active
                   && !shutdown_reg && !undervoltage_i
                   && !thermal_shutdown_i;

   // Brake wins over all; lowers wait for uppers to be seen off
   assign upper_next = brake_s ? 3'h0 :
                       (run_ok ? run_upper : 3'h0);
   assign lower_next = brake_s ?
                       ((upper_on_reg == 3'h0) ? 3'h7 : 3'h0) :
                       (run_ok ? run_lower : 3'h0);

   // Fault collects every protective condition
   assign fault_next = !code_valid || !enable_s || limit_active
                       || undervoltage_i || thermal_shutdown_i
                       || shutdown_reg;

   // Drive and fault outputs are registered so they never glitch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upper_on_reg <= 3'h0;
         lower_on_reg <= 3'h0;
         fault_reg <= 1'b0;
      end else begin
         upper_on_reg <= upper_next;
         lower_on_reg <= lower_next;
         fault_reg <= fault_next;
      end
   end

   assign upper_drive_a_n_o = ~upper_on_reg[0];
   assign upper_drive_b_n_o = ~upper_on_reg[1];
   assign upper_drive_c_n_o = ~upper_on_reg[2];
   assign lower_drive_a_o = lower_on_reg[0];
   assign lower_drive_b_o = lower_on_reg[1];
   assign lower_drive_c_o = lower_on_reg[2];
   // Open drain: pull low only while a fault stands
   assign fault_out_o = 1'b0;
   assign fault_oe_n_o = ~fault_reg;

   // Oscillator divider gives a one-cycle start pulse per period
   assign osc_start = osc_cnt_reg == OSC_LAST;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_cnt_reg <= '0;
      end else begin
         osc_cnt_reg <= osc_start ? '0 : osc_cnt_reg + 1'b1;
      end
   end

   // Cycle limit latch; a trip in the start cycle survives the clear
   assign limit_next = osc_start ? current_sense_i :
                       (limit_reg | current_sense_i);

   // Delay counter restarts after a full oscillator cycle without limit
   assign delay_cnt_next =
      !latch_mode_reg ? '0 :
      (osc_start && !(seen_reg || limit_active)) ? '0 :
      (limit_active && delay_cnt_reg != DELAY_LAST) ?
      delay_cnt_reg + 1'b1 : delay_cnt_reg;
   assign shutdown_set = latch_mode_reg && limit_active
                         && delay_cnt_reg == DELAY_LAST;
   assign shutdown_clear = wr_take && hit_ctrl
                           && wb_dat_i[bldc_pkg::CTRL_SHUTDOWN_CLEAR_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         limit_reg <= 1'b0;
         seen_reg <= 1'b0;
         delay_cnt_reg <= '0;
         shutdown_reg <= 1'b0;
         invalid_reg <= 1'b0;
      end else begin
         limit_reg <= limit_next;
         seen_reg <= osc_start ? 1'b0 : (seen_reg | limit_active);
         delay_cnt_reg <= delay_cnt_next;
         // Set wins over a clear written in the same cycle
         shutdown_reg <= shutdown_set | (shutdown_reg & ~shutdown_clear);
         invalid_reg <= ~code_valid;
      end
   end

   // Wishbone decode on word address; low address bits ignored
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_take = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
   assign word_adr = wb_adr_i[7:2];
   assign hit_ctrl = word_adr == bldc_pkg::CTRL_OFFSET[7:2];
   assign hit_status = word_adr == bldc_pkg::STATUS_OFFSET[7:2];
   assign hit_irq_status = word_adr == bldc_pkg::IRQ_STATUS_OFFSET[7:2];
   assign hit_irq_mask = word_adr == bldc_pkg::IRQ_MASK_OFFSET[7:2];

   assign status_word = {15'h0000,
                         lower_on_reg,
                         upper_on_reg,
                         fault_reg,
                         shutdown_reg,
                         limit_reg,
                         code_valid,
                         sel60_s,
                         brake_s,
                         enable_s,
                         direction_s,
                         sensor_code};
   // Unmapped words read as zero but are still acknowledged
   assign rd_mux = hit_ctrl ? {31'h00000000, latch_mode_reg} :
                   hit_status ? status_word :
                   hit_irq_status ? {28'h0000000, irq_status_reg} :
                   hit_irq_mask ? {28'h0000000, irq_mask_reg} :
                   32'h00000000;

   // One wait state: ack one edge after the request, then drops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rd_data_reg <= 32'h00000000;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
         if (bus_req && !ack_reg) begin
            rd_data_reg <= rd_mux;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rd_data_reg;

   // Control and mask registers written on the acknowledged edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_mode_reg <= bldc_pkg::CTRL_LATCH_MODE_RESET;
         irq_mask_reg <= bldc_pkg::IRQ_MASK_RESET;
      end else if (wr_take && hit_ctrl) begin
         latch_mode_reg <= wb_dat_i[bldc_pkg::CTRL_LATCH_MODE_BIT];
      end else if (wr_take && hit_irq_mask) begin
         irq_mask_reg <= wb_dat_i[bldc_pkg::IRQ_W-1:0];
      end
   end

   // Sticky events; a new event outranks a write-one clear
   assign events[bldc_pkg::IRQ_FAULT_BIT] = fault_next & ~fault_reg;
   assign events[bldc_pkg::IRQ_LIMIT_BIT] = current_sense_i & ~limit_reg;
   assign events[bldc_pkg::IRQ_SHUTDOWN_BIT] = shutdown_set & ~shutdown_reg;
   assign events[bldc_pkg::IRQ_INVALID_BIT] = ~code_valid & ~invalid_reg;
   assign w1c = (wr_take && hit_irq_status) ?
                wb_dat_i[bldc_pkg::IRQ_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_reg <= '0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~w1c) | events;
      end
   end

   assign irq_o = |(irq_status_reg & irq_mask_reg);

   // Checks on the registered drives, fault pin, limit latch, sensor decode and input synchroniser
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence brake_wait_s;
      brake_s && upper_on_reg != 3'h0 ##1 brake_s;
   endsequence

   sequence limit_trip_s;
      current_sense_i && !brake_s ##1 !osc_start && !brake_s;
   endsequence

   brake_order_a: assert property (brake_wait_s |=>
      lower_on_reg == 3'h7 && upper_on_reg == 3'h0)
      else $error("brake did not engage lowers after uppers off");

   brake_block_a: assert property (brake_s |=>
      upper_on_reg == 3'h0 && (lower_on_reg == 3'h0 ||
      lower_on_reg == 3'h7))
      else $error("brake did not stop commutation");

   coast_off_a: assert property (!rst_i && !enable_s &&
      !brake_s |=> upper_on_reg == 3'h0 && lower_on_reg == 3'h0 &&
      fault_reg)
      else $error("disabled motor not coasting");

   invalid_off_a: assert property (!rst_i && !code_valid &&
      !brake_s |=> upper_on_reg == 3'h0 && lower_on_reg == 3'h0 &&
      fault_reg)
      else $error("invalid code did not force drives off");

   limit_hold_a: assert property (limit_trip_s |->
      limit_reg ##1 upper_on_reg == 3'h0 && lower_on_reg == 3'h0)
      else $error("current trip did not end conduction");

   limit_clear_a: assert property (osc_start && !current_sense_i
      |=> !limit_reg)
      else $error("limit latch not cleared at cycle start");

   fault_cause_a: assert property ((undervoltage_i ||
      thermal_shutdown_i || current_sense_i) |=> !fault_oe_n_o)
      else $error("fault pin not pulled low");

   commutate_dir_a: assert property (run_ok && !brake_s |=>
      upper_on_reg == $past(direction_s ? fwd_phases[2:0] :
      fwd_phases[5:3]) && lower_on_reg == $past(direction_s ?
      fwd_phases[5:3] : fwd_phases[2:0]))
      else $error("drive pattern does not match sensor step");

   phasing_sel_a: assert property ((sensor_code == 3'h7 ||
      sensor_code == 3'h0) |-> code_valid == sel60_s)
      else $error("phasing select does not pick the valid codes");

   shutdown_latch_a: assert property (shutdown_set |=>
      shutdown_reg ##1 upper_on_reg == 3'h0 || brake_s)
      else $error("latched shutdown not entered");

   sync_delay_a: assert property (!$past(rst_i) &&
      !$past(rst_i, 2) |-> sync_bits == $past(raw_bits, 2))
      else $error("inputs not delayed by two flops");

endmodule : bldc_commutation_control

// ===== design/bldc_pkg.sv
package bldc_pkg;

   // Clock and oscillator timing
   localparam int CLK_FREQ_HZ = 40_000_000;
   localparam int OSC_FREQ_HZ = 25_000;
   localparam int OSC_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
   localparam int OSC_CNT_W = $clog2(OSC_CYCLES);

   // Persistent current limit delay before latched shutdown
   localparam int SHUTDOWN_DELAY_US = 1000;
   localparam int SHUTDOWN_DELAY_CYCLES =
      SHUTDOWN_DELAY_US * (CLK_FREQ_HZ / 1_000_000);

   // Register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0c;

   // Control register fields
   localparam int CTRL_LATCH_MODE_BIT = 0;
   localparam int CTRL_SHUTDOWN_CLEAR_BIT = 1;
   localparam logic CTRL_LATCH_MODE_RESET = 1'b0;

   // Status register fields
   localparam int STAT_CODE_LSB = 0;
   localparam int STAT_DIRECTION_BIT = 3;
   localparam int STAT_ENABLE_BIT = 4;
   localparam int STAT_BRAKE_BIT = 5;
   localparam int STAT_SEL60_BIT = 6;
   localparam int STAT_VALID_BIT = 7;
   localparam int STAT_LIMIT_BIT = 8;
   localparam int STAT_SHUTDOWN_BIT = 9;
   localparam int STAT_FAULT_BIT = 10;
   localparam int STAT_UPPER_LSB = 11;
   localparam int STAT_LOWER_LSB = 14;

   // Interrupt status and mask fields
   localparam int IRQ_W = 4;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_LIMIT_BIT = 1;
   localparam int IRQ_SHUTDOWN_BIT = 2;
   localparam int IRQ_INVALID_BIT = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

   // Commutation step code for an invalid sensor pattern
   localparam logic [2:0] STEP_INVALID = 3'h7;

endpackage : bldc_pkg

// ===== design/input_sync.sv
`timescale 1ns/1ps

module input_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Raw and synchronised levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // Two flops; only the second stage is visible outside
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule : input_sync

// ===== testbench/hall_bridge_model.sv
`timescale 1ns/1ps

module hall_bridge_model (
   // Rotor step and fault injection from the bench
   input wire logic [2:0] step_i,
   input wire logic [1:0] bad_i,
   input wire logic sel60_i,
   // Bridge gate levels from the controller
   input wire logic [2:0] upper_n_i,
   input wire logic [2:0] lower_i,
   // Sensor levels {A,B,C} and bridge overlap flag
   output logic [2:0] sensor_o,
   output logic overlap_o
);
   // Sensor pattern per step; index 0 sits in the top bits
   function automatic logic [2:0] code_of(input logic s60,
                                          input logic [2:0] st);
      logic [17:0] t;
      t = s60 ? 18'o467310 : 18'o462315;
      return t[17-3*st -: 3];
   endfunction : code_of

   // A broken or shorted sensor line gives one of the two dead codes
   assign sensor_o = (bad_i == 2'h1) ? (sel60_i ? 3'h5 : 3'h7) :
                     (bad_i == 2'h2) ? (sel60_i ? 3'h2 : 3'h0) :
                     code_of(sel60_i, step_i);
   // Upper and lower of one phase both on would short the supply
   assign overlap_o = |(~upper_n_i & lower_i);
endmodule : hall_bridge_model

// ===== testbench/tb.sv
`timescale 1ns/1ps

module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] step = 3'h0;
   logic [1:0] bad = 2'h0;
   logic dir = 1'b1;
   logic run_en = 1'b1;
   logic brake = 1'b0;
   logic sel60 = 1'b1;
   logic sense = 1'b0;
   logic uv = 1'b0;
   logic hot = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, q;
   logic [2:0] sens, up_n, lo;
   logic fault_d, flt_n, ack, irq, overlap;
   logic [2:0] upt [6] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h4};
   logic [2:0] lot [6] = '{3'h1, 3'h1, 3'h4, 3'h4, 3'h2, 3'h2};
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   int s, d, k;

   bldc_commutation_control #(.SHUTDOWN_DELAY_CYCLES(20)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i),
      .position_sensor_a_i(sens[2]), .position_sensor_b_i(sens[1]),
      .position_sensor_c_i(sens[0]), .direction_i(dir),
      .run_enable_i(run_en), .brake_i(brake), .phase_60_select_i(sel60),
      .current_sense_i(sense), .undervoltage_i(uv),
      .thermal_shutdown_i(hot), .upper_drive_a_n_o(up_n[2]),
      .upper_drive_b_n_o(up_n[1]), .upper_drive_c_n_o(up_n[0]),
      .lower_drive_a_o(lo[2]), .lower_drive_b_o(lo[1]),
      .lower_drive_c_o(lo[0]), .fault_out_o(fault_d),
      .fault_oe_n_o(flt_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .irq_o(irq));

   hall_bridge_model u_far (.step_i(step), .bad_i(bad), .sel60_i(sel60),
      .upper_n_i(up_n), .lower_i(lo), .sensor_o(sens),
      .overlap_o(overlap));

   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   // Hang guard, and a bridge overlap is never allowed
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (!rst_i && overlap === 1'b1) begin
         $display("[FAIL] t=%0t got %h exp %h", $time, overlap, 1'b0);
         mismatches++;
      end
      if (cycles == 20000) begin
         $display("[FAIL] t=%0t got %h exp %h", $time, cycles, 0);
         mismatches++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
         mismatches++;
      end
   endtask : chk

   // Upper masks are on-sets, the pins themselves are active low
   task automatic chk_run(input logic [2:0] u, input logic [2:0] l);
      chk({up_n, lo}, {~u, l});
   endtask : chk_run

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wait_n

   // Classic single cycle; the request stands until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] dv, output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= dv;
      sel <= 4'hf;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   // Main sequence
   initial begin
      wait_n(5);
      rst_i <= 1'b0;
      wait_n(5);
      wb(1'b0, bldc_pkg::CTRL_OFFSET, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b0, bldc_pkg::IRQ_MASK_OFFSET, 32'h0, q);
      chk(q, 32'h0);
      // Every step, both phasings, both directions
      for (s = 0; s < 2; s++) for (d = 0; d < 2; d++)
         for (k = 0; k < 6; k++) begin
            sel60 <= s[0];
            dir <= d[0];
            step <= k[2:0];
            wait_n(5);
            if (d == 1) chk_run(upt[k], lot[k]);
            else chk_run(lot[k], upt[k]);
            chk(flt_n, 1'b1);
         end
      // The two dead codes of each phasing
      for (s = 0; s < 2; s++) for (k = 1; k < 3; k++) begin
         sel60 <= s[0];
         bad <= k[1:0];
         wait_n(5);
         chk_run(3'h0, 3'h0);
         chk(flt_n, 1'b0);
      end
      bad <= 2'h0;
      sel60 <= 1'b1;
      step <= 3'h0;
      wait_n(5);
      wb(1'b0, bldc_pkg::STATUS_OFFSET, 32'h0, q);
      chk(q & 32'h7ff, 32'h0dc);
      chk(fault_d, 1'b0);
      step <= 3'h1;
      wait_n(2);
      chk_run(upt[0], lot[0]);
      wait_n(4);
      chk_run(upt[1], lot[1]);
      step <= 3'h0;
      wait_n(5);
      // Disable, undervoltage, overtemperature
      for (k = 0; k < 3; k++) begin
         run_en <= (k != 0);
         uv <= (k == 1);
         hot <= (k == 2);
         wait_n(5);
         chk_run(3'h0, 3'h0);
         chk(flt_n, 1'b0);
         run_en <= 1'b1;
         uv <= 1'b0;
         hot <= 1'b0;
         wait_n(5);
         chk_run(upt[0], lot[0]);
      end
      // Brake wins even over disable and a dead code
      brake <= 1'b1;
      wait_n(5);
      chk_run(3'h0, 3'h7);
      chk(flt_n, 1'b1);
      run_en <= 1'b0;
      bad <= 2'h1;
      wait_n(5);
      chk_run(3'h0, 3'h7);
      brake <= 1'b0;
      run_en <= 1'b1;
      bad <= 2'h0;
      wait_n(5);
      chk_run(upt[0], lot[0]);
      // Cycle-by-cycle limit holds to the next oscillator start
      sense <= 1'b1;
      wait_n(3);
      chk_run(3'h0, 3'h0);
      chk(flt_n, 1'b0);
      sense <= 1'b0;
      k = 0;
      while (up_n[2] !== 1'b0 && k < 1700) begin
         wait_n(1);
         k++;
      end
      chk_run(upt[0], lot[0]);
      // Right after a cycle start a one-cycle trip holds to the next
      sense <= 1'b1;
      wait_n(1);
      sense <= 1'b0;
      wait_n(3);
      chk_run(3'h0, 3'h0);
      // Persistent limit in latch mode; only a clear restarts
      wb(1'b1, bldc_pkg::CTRL_OFFSET, 32'h1, q);
      sense <= 1'b1;
      wait_n(30);
      sense <= 1'b0;
      wait_n(1700);
      chk_run(3'h0, 3'h0);
      wb(1'b0, bldc_pkg::STATUS_OFFSET, 32'h0, q);
      chk(q[9], 1'b1);
      wb(1'b1, bldc_pkg::CTRL_OFFSET, 32'h2, q);
      wait_n(5);
      chk_run(upt[0], lot[0]);
      // Interrupt: clear, raise, mask, clear while cause persists
      wb(1'b0, bldc_pkg::IRQ_STATUS_OFFSET, 32'h0, q);
      chk(q, 32'hf);
      wb(1'b1, bldc_pkg::IRQ_STATUS_OFFSET, 32'hf, q);
      wb(1'b0, bldc_pkg::IRQ_STATUS_OFFSET, 32'h0, q);
      chk(q, 32'h0);
      bad <= 2'h1;
      wait_n(5);
      wb(1'b0, bldc_pkg::IRQ_STATUS_OFFSET, 32'h0, q);
      chk(q, 32'h9);
      chk(irq, 1'b0);
      wb(1'b1, bldc_pkg::IRQ_MASK_OFFSET, 32'h8, q);
      chk(irq, 1'b1);
      wb(1'b1, bldc_pkg::IRQ_STATUS_OFFSET, 32'h8, q);
      chk(irq, 1'b0);
      wb(1'b0, bldc_pkg::IRQ_STATUS_OFFSET, 32'h0, q);
      chk(q, 32'h1);
      // Unmapped place reads zero and ignores writes
      wb(1'b1, 8'h10, 32'hffff_ffff, q);
      wb(1'b0, 8'h10, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b0, bldc_pkg::CTRL_OFFSET, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b0, bldc_pkg::IRQ_MASK_OFFSET, 32'h0, q);
      chk(q, 32'h8);
      close_out();
   end
endmodule : tb
